// >>> hw/smt_pkg.sv
// Package of constants, types and register map for the synchronous master serial transmitter.
package smt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_TX_CTRL = 8'h00;
  localparam logic [7:0] ADR_RX_CTRL = 8'h04;
  localparam logic [7:0] ADR_BAUD_CTRL = 8'h08;
  localparam logic [7:0] ADR_DIV_LOW = 8'h0c;
  localparam logic [7:0] ADR_DIV_HIGH = 8'h10;
  localparam logic [7:0] ADR_TX_BUF = 8'h14;
  localparam logic [7:0] ADR_FLAGS = 8'h18;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADR_INT_CTRL = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TXC_MASTER = 7;
  localparam int TXC_NINTH_EN = 6;
  localparam int TXC_TX_EN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_SHIFT_EMPTY = 1;
  localparam int TXC_NINTH_VAL = 0;
  localparam int RXC_PORT_EN = 7;
  localparam int RXC_RX_EN = 4;
  localparam int RXC_DATA_LVL = 0;
  localparam int BDC_POLARITY = 4;
  localparam int BDC_WIDE = 3;
  localparam int FLG_BUF_EMPTY = 0;
  localparam int FLG_RX_INHIBIT = 1;
  localparam int EVT_BUF_EMPTY = 0;
  localparam int EVT_WORD_DONE = 1;
  localparam int INC_GLOBAL = 7;
  localparam int INC_PERIPH = 6;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [3:0] BITS_NARROW = 4'h8;
  localparam logic [3:0] BITS_WIDE = 4'h9;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT} smt_state_e;

  // Wishbone request as seen by the slave.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } smt_wb_req_s;

endpackage

// >>> hw/smt_sync_master_tx.sv
// Synchronous master serial transmitter with a classic Wishbone register slave.
// Function
// - Clock-master select bit 7 of transmit control makes the block drive the clock.
// - Half-duplex: transmitting blocks reception and receiving blocks transmission.
// - Sync mode bit 4 of transmit control selects synchronous operation.
// - Port enable bit 7 of receive control claims the clock and data lines.
// - In master mode the shift clock is driven onto the clock line.
// - Clock idle level follows polarity bit 4 of baud control.
// - Shift register reloads only after the last bit, then at once if data waits.
// - Buffer to shift register move takes one cycle and sets buffer-empty flag.
// - Buffer-empty flag sets regardless of its interrupt enable.
// - Buffer-empty flag clears only by writing the transmit buffer.
// - Read-only shift-empty bit 1 of transmit control, polled, no interrupt.
// - The shift register itself has no address.
// - Transmit enable allows it; writing the buffer starts a transfer.
module smt_sync_master_tx (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Interrupt
  output logic IRQ_OUT,
  // Serial clock line
  input wire logic SCLK_IN,
  output logic SCLK_OUT,
  output logic SCLK_OE_OUT,
  // Serial data line
  input wire logic SDATA_IN,
  output logic SDATA_OUT,
  output logic SDATA_OE_OUT
);

  // ----------------------------------------------------------------
  // Registers and helpers
  // ----------------------------------------------------------------
  // All software state lives in byte-wide registers on lane 0 of the bus.
  // The upper lanes read as zero and are ignored on writes, which keeps the
  // decode small at the cost of one access per register.
  // The clock line is only claimed when the port is enabled in synchronous
  // master mode; otherwise the pin is left to whatever else shares it.
  smt_pkg::smt_wb_req_s req;
  smt_pkg::smt_state_e st_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0] tx_ctrl_ff, rx_ctrl_ff, baud_ctrl_ff, div_low_ff, div_high_ff, int_ctrl_ff;
  logic [7:0] buf_ff;
  logic buf_full_ff;
  logic [1:0] irq_stat_ff, irq_mask_ff;
  logic irq_ff;
  logic [8:0] shift_ff;
  logic [3:0] bits_ff;
  logic [15:0] cnt_ff;
  logic phase_ff;
  logic sclk_ff, sclk_oe_ff, sdata_ff, sdata_oe_ff;
  logic sck_s1_ff, sck_s2_ff, sck_s3_ff, dat_s1_ff, dat_s2_ff;
  logic wr, wr_buf, master, polarity, can_go, lead_ev, trail_ev, load_ev, done_ev;
  logic [15:0] divisor;
  logic [31:0] rd_mux;

  // Byte lane 0 merge used by the control, baud, divisor and interrupt control registers.
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
    wr_byte = sel[0] ? dat[7:0] : old;
  endfunction

  assign req = '{cyc: WB_CYC_IN, stb: WB_STB_IN, we: WB_WE_IN, adr: WB_ADR_IN,
                 sel: WB_SEL_IN, dat: WB_DAT_IN};
  // Writes land on the edge where the master samples ack.
  assign wr = req.cyc & req.stb & req.we & ack_ff;
  assign wr_buf = wr & (req.adr == smt_pkg::ADR_TX_BUF) & req.sel[0];
  assign master = tx_ctrl_ff[smt_pkg::TXC_MASTER];
  assign polarity = baud_ctrl_ff[smt_pkg::BDC_POLARITY];
  // Port enable, sync mode and transmit enable are all needed; active receive blocks it.
  assign can_go = rx_ctrl_ff[smt_pkg::RXC_PORT_EN] & tx_ctrl_ff[smt_pkg::TXC_SYNC]
                  & tx_ctrl_ff[smt_pkg::TXC_TX_EN]
                  & ~rx_ctrl_ff[smt_pkg::RXC_RX_EN];
  assign divisor = baud_ctrl_ff[smt_pkg::BDC_WIDE] ? {div_high_ff, div_low_ff}
                                                   : {8'h00, div_low_ff};
  assign load_ev = (st_ff == smt_pkg::ST_LOAD);
  assign done_ev = (st_ff == smt_pkg::ST_SHIFT) & trail_ev & (bits_ff == 4'h1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Both line inputs come from pins and may change at any time relative to
  // the system clock. Two flip-flops settle them before any logic reads them.
  // The third clock stage exists only to find edges on the settled value.
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end else begin
      sck_s1_ff <= SCLK_IN;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      dat_s1_ff <= SDATA_IN;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Clock edge events
  // ----------------------------------------------------------------
  // Master mode times each half period from the divisor; otherwise an external
  // clock on the line is followed, which costs three cycles of latency.
  always_comb begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (st_ff == smt_pkg::ST_SHIFT) begin
      if (master) begin
        lead_ev = (cnt_ff == 16'h0000) & ~phase_ff;
        trail_ev = (cnt_ff == 16'h0000) & phase_ff;
      end else begin
        lead_ev = (sck_s2_ff != sck_s3_ff) & (sck_s2_ff != polarity);
        trail_ev = (sck_s2_ff != sck_s3_ff) & (sck_s2_ff == polarity);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cnt_ff <= 16'h0000;
      phase_ff <= 1'b0;
      sclk_ff <= 1'b0;
      sclk_oe_ff <= 1'b0;
    end else begin
      sclk_oe_ff <= master & rx_ctrl_ff[smt_pkg::RXC_PORT_EN]
                    & tx_ctrl_ff[smt_pkg::TXC_SYNC];
      if (st_ff != smt_pkg::ST_SHIFT) begin
        cnt_ff <= divisor;
        phase_ff <= 1'b0;
        sclk_ff <= polarity;
      end else if (lead_ev) begin
        cnt_ff <= divisor;
        phase_ff <= 1'b1;
        sclk_ff <= ~polarity;
      end else if (trail_ev) begin
        cnt_ff <= divisor;
        phase_ff <= 1'b0;
        sclk_ff <= polarity;
      end else if (master) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit state machine and shift register
  // ----------------------------------------------------------------
  // The word leaves least significant bit first. The first bit is placed on
  // the data line during the load cycle, so it is settled a full idle half
  // period before the first sampling edge.
  // Losing any of the enables aborts the word at once; the partly sent word
  // is dropped and the line returns to idle.
  // The shift register has no bus address and can only be seen through the
  // shift-empty bit and the receive-inhibit flag.
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_ff <= smt_pkg::ST_IDLE;
      shift_ff <= 9'h000;
      bits_ff <= 4'h0;
      sdata_ff <= 1'b0;
      sdata_oe_ff <= 1'b0;
    end else begin
      sdata_oe_ff <= can_go & (st_ff != smt_pkg::ST_IDLE);
      case (st_ff)
        smt_pkg::ST_IDLE: begin
          if (buf_full_ff & can_go) begin
            st_ff <= smt_pkg::ST_LOAD;
          end
        end
        smt_pkg::ST_LOAD: begin
          // One cycle to move the buffer into the shift register.
          shift_ff <= {tx_ctrl_ff[smt_pkg::TXC_NINTH_VAL], buf_ff};
          bits_ff <= tx_ctrl_ff[smt_pkg::TXC_NINTH_EN] ? smt_pkg::BITS_WIDE
                                                       : smt_pkg::BITS_NARROW;
          sdata_ff <= buf_ff[0];
          st_ff <= can_go ? smt_pkg::ST_SHIFT : smt_pkg::ST_IDLE;
        end
        smt_pkg::ST_SHIFT: begin
          if (!can_go) begin
            st_ff <= smt_pkg::ST_IDLE;
          end else if (trail_ev) begin
            if (bits_ff == 4'h1) begin
              // Reload straight after the last bit only if a word waits.
              st_ff <= buf_full_ff ? smt_pkg::ST_LOAD : smt_pkg::ST_IDLE;
            end else begin
              // Data moves on the return-to-idle edge, opposite the sampling edge.
              shift_ff <= {1'b0, shift_ff[8:1]};
              sdata_ff <= shift_ff[1];
              bits_ff <= bits_ff - 4'h1;
            end
          end
        end
        default: begin
          st_ff <= smt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // A write in the same cycle as a load keeps the new word: the load took the old one.
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      buf_ff <= smt_pkg::RST_BYTE;
      buf_full_ff <= 1'b0;
    end else begin
      if (wr_buf) begin
        buf_ff <= req.dat[7:0];
        buf_full_ff <= 1'b1;
      end else if (load_ev) begin
        buf_full_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tx_ctrl_ff <= smt_pkg::RST_BYTE;
      rx_ctrl_ff <= smt_pkg::RST_BYTE;
      baud_ctrl_ff <= smt_pkg::RST_BYTE;
      div_low_ff <= smt_pkg::RST_BYTE;
      div_high_ff <= smt_pkg::RST_BYTE;
      int_ctrl_ff <= smt_pkg::RST_BYTE;
      irq_mask_ff <= smt_pkg::RST_EVT;
    end else if (wr) begin
      case (req.adr)
        smt_pkg::ADR_TX_CTRL: tx_ctrl_ff <= wr_byte(tx_ctrl_ff, req.sel, req.dat);
        smt_pkg::ADR_RX_CTRL: rx_ctrl_ff <= wr_byte(rx_ctrl_ff, req.sel, req.dat);
        smt_pkg::ADR_BAUD_CTRL: baud_ctrl_ff <= wr_byte(baud_ctrl_ff, req.sel, req.dat);
        smt_pkg::ADR_DIV_LOW: div_low_ff <= wr_byte(div_low_ff, req.sel, req.dat);
        smt_pkg::ADR_DIV_HIGH: div_high_ff <= wr_byte(div_high_ff, req.sel, req.dat);
        smt_pkg::ADR_INT_CTRL: int_ctrl_ff <= wr_byte(int_ctrl_ff, req.sel, req.dat);
        smt_pkg::ADR_IRQ_MASK: begin
          irq_mask_ff <= req.sel[0] ? req.dat[1:0] : irq_mask_ff;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // The status bits are sticky and are cleared by writing a one. The mask
  // only gates the request line, so software can always poll the status.
  // The request line is registered and lags the status by one cycle.
  // Events win over a write-one clear in the same cycle so none is lost.
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_stat_ff <= smt_pkg::RST_EVT;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr && req.adr == smt_pkg::ADR_IRQ_STAT && req.sel[0])
                                      ? req.dat[1:0] : 2'h0))
                     | {done_ev, load_ev};
      irq_ff <= (|(irq_stat_ff & irq_mask_ff)) & int_ctrl_ff[smt_pkg::INC_GLOBAL]
                & int_ctrl_ff[smt_pkg::INC_PERIPH];
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read path
  // ----------------------------------------------------------------
  // Read data is captured when the request is first seen and then held, so
  // the master may take it at the acknowledge edge without a combinational
  // path from the address to the data output.
  // Unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req.adr)
      smt_pkg::ADR_TX_CTRL: begin
        rd_mux[7:0] = tx_ctrl_ff;
        rd_mux[smt_pkg::TXC_SHIFT_EMPTY] = (st_ff == smt_pkg::ST_IDLE);
      end
      smt_pkg::ADR_RX_CTRL: begin
        rd_mux[7:0] = rx_ctrl_ff;
        rd_mux[smt_pkg::RXC_DATA_LVL] = dat_s2_ff;
      end
      smt_pkg::ADR_BAUD_CTRL: rd_mux[7:0] = baud_ctrl_ff;
      smt_pkg::ADR_DIV_LOW: rd_mux[7:0] = div_low_ff;
      smt_pkg::ADR_DIV_HIGH: rd_mux[7:0] = div_high_ff;
      smt_pkg::ADR_TX_BUF: rd_mux[7:0] = buf_ff;
      smt_pkg::ADR_FLAGS: begin
        rd_mux[smt_pkg::FLG_BUF_EMPTY] = ~buf_full_ff;
        rd_mux[smt_pkg::FLG_RX_INHIBIT] = (st_ff != smt_pkg::ST_IDLE);
      end
      smt_pkg::ADR_IRQ_STAT: rd_mux[1:0] = irq_stat_ff;
      smt_pkg::ADR_IRQ_MASK: rd_mux[1:0] = irq_mask_ff;
      smt_pkg::ADR_INT_CTRL: rd_mux[7:0] = int_ctrl_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Every access, mapped or not, is acknowledged one cycle after the strobe.
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req.cyc & req.stb & ~ack_ff;
      if (req.cyc & req.stb & ~ack_ff & ~req.we) begin
        rdat_ff <= rd_mux;
      end
    end
  end

  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = rdat_ff;
  assign IRQ_OUT = irq_ff;
  assign SCLK_OUT = sclk_ff;
  assign SCLK_OE_OUT = sclk_oe_ff;
  assign SDATA_OUT = sdata_ff;
  assign SDATA_OE_OUT = sdata_oe_ff;

endmodule // smt_sync_master_tx

// >>> testbench/smt_slave_model.sv
// Behavioural synchronous slave that collects the bits shifted out by the master.
module smt_slave_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial lines
  input wire logic sclk_line_in,
  input wire logic sdata_line_in,
  // Control from the bench
  input wire logic pol_in,
  input wire logic clr_in,
  // Collected bits
  output logic [5:0] nbits_out,
  output logic [31:0] bits_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  // The slave only listens, so the clock line is never driven from here.
  always_ff @(posedge clk_in) begin
    sclk_q <= sclk_line_in;
    if (rst_in || clr_in) begin
      nbits_out <= 6'h00;
      bits_out <= 32'h0;
    end else if (sclk_line_in != pol_in && sclk_q == pol_in) begin
      bits_out[nbits_out[4:0]] <= sdata_line_in;
      nbits_out <= nbits_out + 6'h01;
    end
  end
endmodule // smt_slave_model

// >>> testbench/smt_sync_master_tx_chk.sv
// Port checker of the synchronous master serial transmitter.
module smt_sync_master_tx_chk (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Interrupt and serial lines
  input wire logic IRQ_OUT,
  input wire logic SCLK_IN,
  input wire logic SCLK_OUT,
  input wire logic SCLK_OE_OUT,
  input wire logic SDATA_IN,
  input wire logic SDATA_OUT,
  input wire logic SDATA_OE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [7:0] txc_ff;
  logic [7:0] rxc_ff;
  logic [7:0] bdc_ff;
  logic [7:0] div_ff;
  logic [7:0] inc_ff;
  logic [15:0] hcnt_ff;
  logic sclk_q_ff;
  logic wr;
  logic pol;
  logic drv;
  logic ok;
  logic en;
  // Register copies are rebuilt from the bus so only ports are watched.
  assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_ACK_OUT & WB_SEL_IN[0];
  assign pol = bdc_ff[smt_pkg::BDC_POLARITY];
  assign drv = txc_ff[smt_pkg::TXC_MASTER] & rxc_ff[smt_pkg::RXC_PORT_EN] &
               txc_ff[smt_pkg::TXC_SYNC];
  assign ok = txc_ff[smt_pkg::TXC_SYNC] & txc_ff[smt_pkg::TXC_TX_EN] &
              rxc_ff[smt_pkg::RXC_PORT_EN] & ~rxc_ff[smt_pkg::RXC_RX_EN];
  assign en = inc_ff[smt_pkg::INC_GLOBAL] & inc_ff[smt_pkg::INC_PERIPH];
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      txc_ff <= 8'h00;
      rxc_ff <= 8'h00;
      bdc_ff <= 8'h00;
      div_ff <= 8'h00;
      inc_ff <= 8'h00;
    end else if (wr) begin
      if (WB_ADR_IN == smt_pkg::ADR_TX_CTRL) txc_ff <= WB_DAT_IN[7:0];
      if (WB_ADR_IN == smt_pkg::ADR_RX_CTRL) rxc_ff <= WB_DAT_IN[7:0];
      if (WB_ADR_IN == smt_pkg::ADR_BAUD_CTRL) bdc_ff <= WB_DAT_IN[7:0];
      if (WB_ADR_IN == smt_pkg::ADR_DIV_LOW) div_ff <= WB_DAT_IN[7:0];
      if (WB_ADR_IN == smt_pkg::ADR_INT_CTRL) inc_ff <= WB_DAT_IN[7:0];
    end
  end
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sclk_q_ff <= 1'b0;
      hcnt_ff <= 16'h0000;
    end else begin
      sclk_q_ff <= SCLK_OUT;
      hcnt_ff <= (SCLK_OUT != sclk_q_ff) ? 16'h0001 : hcnt_ff + 16'h0001;
    end
  end
  chk_clock_drive_owner: assert property (drv == $past(drv) |-> SCLK_OE_OUT == drv)
    else $error("clock drive does not follow master and port enable");
  chk_data_drive_gate: assert property (!ok && !$past(ok) && !$past(ok, 2) |-> !SDATA_OE_OUT)
    else $error("data line driven while transmit is not allowed");
  chk_clock_idle_level: assert property (SCLK_OE_OUT && !SDATA_OE_OUT && !$fell(SDATA_OE_OUT) && $stable(pol) |-> SCLK_OUT == pol)
    else $error("clock line not at idle level");
  chk_data_change_idle: assert property (SDATA_OE_OUT && $past(SDATA_OE_OUT) && $changed(SDATA_OUT) |-> SCLK_OUT == pol)
    else $error("data changed while clock active");
  chk_data_hold_active: assert property (SDATA_OE_OUT && SCLK_OUT != pol && $past(SCLK_OUT) != pol |-> $stable(SDATA_OUT))
    else $error("data moved during active clock phase");
  chk_half_period_len: assert property (SDATA_OE_OUT && SCLK_OUT != sclk_q_ff && SCLK_OUT == pol |-> hcnt_ff == {8'h00, div_ff} + 16'h0001)
    else $error("active clock phase length wrong");
  chk_irq_global_gate: assert property (!en && !$past(en) |-> !IRQ_OUT)
    else $error("interrupt raised with global enables clear");
  chk_ack_single_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("acknowledge longer than one cycle");
endmodule // smt_sync_master_tx_chk

bind smt_sync_master_tx smt_sync_master_tx_chk chk_u (
  .SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
  .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .IRQ_OUT(IRQ_OUT),
  .SCLK_IN(SCLK_IN), .SCLK_OUT(SCLK_OUT), .SCLK_OE_OUT(SCLK_OE_OUT), .SDATA_IN(SDATA_IN),
  .SDATA_OUT(SDATA_OUT), .SDATA_OE_OUT(SDATA_OE_OUT));

// >>> testbench/test_smt_sync_master_tx.sv
// Self-checking bench of the synchronous master serial transmitter.
module test_smt_sync_master_tx;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic clr = 1'b0;
  logic pol_r = 1'b0;
  logic sd_last = 1'b0;
  logic [31:0] rdat;
  logic ack, irq, sclk_o, sclk_oe, sd_o, sd_oe, sclk_line, sd_line;
  logic [5:0] nb;
  logic [31:0] rxv;
  int n_errors = 0;
  int n_compared = 0;
  // A released data line shows the inverse of its last bit, never a held value.
  assign sclk_line = sclk_oe ? sclk_o : pol_r;
  assign sd_line = sd_oe ? sd_o : ~sd_last;
  always @(posedge clk) if (sd_oe) sd_last <= sd_o;
  smt_sync_master_tx dut_u (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_OUT(irq), .SCLK_IN(sclk_line),
    .SCLK_OUT(sclk_o), .SCLK_OE_OUT(sclk_oe), .SDATA_IN(sd_line), .SDATA_OUT(sd_o),
    .SDATA_OE_OUT(sd_oe));
  smt_slave_model slave_u (.clk_in(clk), .rst_in(rst), .sclk_line_in(sclk_line),
    .sdata_line_in(sd_line), .pol_in(pol_r), .clr_in(clr), .nbits_out(nb), .bits_out(rxv));
  initial forever #2 clk = ~clk;
  task automatic final_report;
    $display("Compared %0d values, %0d errors", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wait_bits(input logic [5:0] n);
    for (int i = 0; i < 3000 && nb !== n; i++) @(posedge clk);
  endtask
  task automatic restart;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(smt_pkg::ADR_FLAGS, 32'h1);
    rd(smt_pkg::ADR_TX_CTRL, 32'h2);
    rd(8'h40, 32'h0);
    rd(smt_pkg::ADR_RX_CTRL, 32'h1);
    wr(smt_pkg::ADR_DIV_LOW, 32'h2);
    wr(smt_pkg::ADR_INT_CTRL, 32'hc0);
    wr(smt_pkg::ADR_RX_CTRL, 32'h80);
    for (int p = 0; p < 2; p++) begin
      pol_r <= p[0];
      wr(smt_pkg::ADR_BAUD_CTRL, {27'h0, p[0], 4'h0});
      wr(smt_pkg::ADR_IRQ_MASK, {31'h0, p[0]});
      wr(smt_pkg::ADR_TX_CTRL, p ? 32'hf1 : 32'hb0);
      repeat (2) @(posedge clk);
      chk({31'h0, sclk_oe}, 32'h1);
      chk({31'h0, sclk_o}, {31'h0, p[0]});
      restart();
      wr(smt_pkg::ADR_TX_BUF, 32'ha5);
      wr(smt_pkg::ADR_TX_BUF, 32'h3c);
      rd(smt_pkg::ADR_FLAGS, 32'h2);
      rd(smt_pkg::ADR_TX_CTRL, p ? 32'hf1 : 32'hb0);
      wait_bits(p ? 6'h12 : 6'h10);
      chk(rxv, p ? {14'h0, 1'b1, 8'h3c, 1'b1, 8'ha5} : {16'h0, 8'h3c, 8'ha5});
      repeat (20) @(posedge clk);
      rd(smt_pkg::ADR_TX_CTRL, p ? 32'hf3 : 32'hb2);
      rd(smt_pkg::ADR_FLAGS, 32'h1);
      rd(smt_pkg::ADR_IRQ_STAT, 32'h3);
      chk({31'h0, irq}, {31'h0, p[0]});
      wr(smt_pkg::ADR_IRQ_STAT, 32'h3);
      rd(smt_pkg::ADR_IRQ_STAT, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      wr(k ? smt_pkg::ADR_RX_CTRL : smt_pkg::ADR_TX_CTRL, 32'h90);
      restart();
      wr(smt_pkg::ADR_TX_BUF, 32'h5a);
      repeat (100) @(posedge clk);
      chk({26'h0, nb}, 32'h0);
      rd(smt_pkg::ADR_FLAGS, 32'h0);
      wr(k ? smt_pkg::ADR_RX_CTRL : smt_pkg::ADR_TX_CTRL, k ? 32'h80 : 32'hb0);
      wait_bits(6'h08);
      chk(rxv, 32'h5a);
    end
    final_report();
  end
endmodule // test_smt_sync_master_tx
